// ==== shared/fcc_consts.svh ====
`ifndef FCC_CONSTS_SVH
`define FCC_CONSTS_SVH

// register indices on the register port
`define FCC_OFS_CLKDIV 3'h0
`define FCC_OFS_CONFIG 3'h1
`define FCC_OFS_PROT 3'h2
`define FCC_OFS_STATUS 3'h3
`define FCC_OFS_CMD 3'h4

// clock divider register fields
`define FCC_BIT_LOADED 7
`define FCC_BIT_PRESCALE 6

// configuration register fields
`define FCC_BIT_CBE_IE 7
`define FCC_BIT_CC_IE 6

// protection register fields
`define FCC_BIT_OPEN 7
`define FCC_BIT_HI_DIS 5
`define FCC_BIT_LO_DIS 2

// status register fields
`define FCC_BIT_CBE 7
`define FCC_BIT_CC 6
`define FCC_BIT_PROTECTION_VIOLATION_FLAG 5
`define FCC_BIT_ACCESS_ERROR_FLAG 4
`define FCC_BIT_BLANK 2

// command codes
`define FCC_CMD_VERIFY 8'h05
`define FCC_CMD_PROGRAM 8'h20
`define FCC_CMD_SECTOR 8'h40
`define FCC_CMD_MASS 8'h41

// reset values
`define FCC_RST_DIV 7'h00
`define FCC_RST_PROT 3'h0
`define FCC_RST_CBE 1'b1
`define FCC_RST_CC 1'b1

// operation lengths in algorithm clock ticks
`define FCC_TICKS_VERIFY 16'h0400
`define FCC_TICKS_PROGRAM 16'h0006
`define FCC_TICKS_SECTOR 16'h0fa0
`define FCC_TICKS_MASS 16'h0fa0

// protection area bounds, byte addresses
`define FCC_LOW_TOP 16'h1000
`define FCC_HIGH_BASE 16'hc000

`endif

// ==== shared/fcc_pkg.sv ====
`default_nettype none
package fcc_pkg;

  typedef enum logic [1:0] {
    FCC_SEQ_IDLE,
    FCC_SEQ_ADDR,
    FCC_SEQ_CMD
  } fcc_seq_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } fcc_job_t;

  typedef struct packed {
    fcc_seq_t seq;
    fcc_job_t buf_job;
    logic buf_valid;
    fcc_job_t act_job;
    logic act_valid;
    logic [15:0] ticks;
    logic [9:0] presc;
    logic [6:0] div;
    logic loaded;
    logic cbe_ie;
    logic cc_ie;
    logic [2:0] prot;
    logic cbe;
    logic cc;
    logic protection_violation_flag;
    logic access_error_flag;
    logic blank;
    logic arr_start;
    logic [7:0] rdata;
  } fcc_state_t;

endpackage
`default_nettype wire

// ==== core/fcc_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcc_consts.svh"

module fcc_controller
  import fcc_pkg::*;
#(
  parameter logic [15:0] TICKS_VERIFY = `FCC_TICKS_VERIFY,
  parameter logic [15:0] TICKS_PROGRAM = `FCC_TICKS_PROGRAM,
  parameter logic [15:0] TICKS_SECTOR = `FCC_TICKS_SECTOR,
  parameter logic [15:0] TICKS_MASS = `FCC_TICKS_MASS,
  parameter logic [15:0] LOW_TOP = `FCC_LOW_TOP,
  parameter logic [15:0] HIGH_BASE = `FCC_HIGH_BASE
)
(
  input wire logic i_sys_clk, // system clock, 100 MHz
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_ce, // clock enable, freezes all state when low
  input wire logic [2:0] i_reg_addr, // register index
  input wire logic [7:0] i_reg_wdata, // register write data
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  output logic [7:0] o_reg_rdata, // read data, cycle after strobe
  input wire logic i_arr_wr, // write into the array address space
  input wire logic [15:0] i_arr_addr, // array byte address
  input wire logic [15:0] i_arr_wdata, // array write word
  input wire logic i_arr_not_erased, // array reports a non-erased word
  output logic o_arr_start, // one-cycle pulse: operation begins
  output logic o_arr_busy, // an operation is active
  output fcc_job_t o_arr_job, // active command, address, data
  output logic o_alg_tick, // one-cycle algorithm clock tick
  output logic o_cbe_irq, // buffer-empty interrupt request
  output logic o_cc_irq // command-complete interrupt request
);

  localparam fcc_state_t RST = '{
    seq: FCC_SEQ_IDLE,
    div: `FCC_RST_DIV,
    prot: `FCC_RST_PROT,
    cbe: `FCC_RST_CBE,
    cc: `FCC_RST_CC,
    default: '0
  };

  fcc_state_t r_reg;
  fcc_state_t r_next;
  logic alg_tick;
  logic verify_miss;
  logic done;
  logic go;
  logic pv_hit;
  logic acc_set;
  logic pv_set;
  logic locked;
  logic [7:0] rd;

  // terminal count of the algorithm clock prescaler
  function automatic logic [9:0] fcc_limit(input logic [6:0] d);
    logic [9:0] base;
    base = {4'h0, d[5:0]} + 10'h001;
    if (d[`FCC_BIT_PRESCALE])
      return {base[6:0], 3'h0} - 10'h001;
    return base - 10'h001;
  endfunction

  function automatic logic fcc_cmd_ok(input logic [7:0] c);
    return (c == `FCC_CMD_VERIFY) || (c == `FCC_CMD_PROGRAM) ||
      (c == `FCC_CMD_SECTOR) || (c == `FCC_CMD_MASS);
  endfunction

  function automatic logic [15:0] fcc_ticks(input logic [7:0] c);
    case (c)
      `FCC_CMD_VERIFY: return TICKS_VERIFY - 16'h0001;
      `FCC_CMD_PROGRAM: return TICKS_PROGRAM - 16'h0001;
      `FCC_CMD_SECTOR: return TICKS_SECTOR - 16'h0001;
      default: return TICKS_MASS - 16'h0001;
    endcase
  endfunction

  // prot holds {open, high disable, low disable}
  function automatic logic fcc_area_locked(input logic [15:0] a, input logic [2:0] p);
    if (a < LOW_TOP)
      return !p[0];
    if (a >= HIGH_BASE)
      return !p[1];
    return !p[2];
  endfunction

  function automatic logic fcc_prot_hit(input fcc_job_t j, input logic [2:0] p);
    case (j.cmd)
      `FCC_CMD_PROGRAM: return fcc_area_locked(j.addr, p);
      `FCC_CMD_SECTOR: return fcc_area_locked({j.addr[15:10], 10'h000}, p);
      `FCC_CMD_MASS: return p != 3'h7;
      default: return 1'b0;
    endcase
  endfunction

  always_comb
  begin
    r_next = r_reg;
    r_next.arr_start = 1'b0;
    r_next.rdata = 8'h00;
    acc_set = 1'b0;
    pv_set = 1'b0;
    go = 1'b0;
    rd = 8'h00;
    locked = r_reg.access_error_flag || r_reg.protection_violation_flag;
    pv_hit = fcc_prot_hit(r_reg.buf_job, r_reg.prot);

    // divided algorithm clock as a tick enable
    // compare as at-or-past: a divider cut short must not leave the count wrapping
    alg_tick = (r_reg.presc >= fcc_limit(r_reg.div));
    r_next.presc = alg_tick ? 10'h000 : r_reg.presc + 10'h001;

    // a failing verify ends at the next tick instead of running on
    verify_miss = (r_reg.act_job.cmd == `FCC_CMD_VERIFY) && i_arr_not_erased;
    done = r_reg.act_valid && alg_tick &&
      ((r_reg.ticks == 16'h0000) || verify_miss);
    if (r_reg.act_valid && alg_tick)
      r_next.ticks = r_reg.ticks - 16'h0001;
    if (done)
    begin
      r_next.act_valid = 1'b0;
      if ((r_reg.act_job.cmd == `FCC_CMD_VERIFY) && !verify_miss)
        r_next.blank = 1'b1;
      if (!r_reg.buf_valid)
        r_next.cc = 1'b1;
    end

    // hand the buffered command to the active stage
    if (r_reg.buf_valid && (!r_reg.act_valid || done))
    begin
      r_next.act_job = r_reg.buf_job;
      r_next.act_valid = 1'b1;
      r_next.buf_valid = 1'b0;
      r_next.cbe = 1'b1;
      r_next.arr_start = 1'b1;
      r_next.ticks = fcc_ticks(r_reg.buf_job.cmd);
    end

    // step one: the array write
    if (i_arr_wr)
    begin
      if (!r_reg.loaded || (r_reg.seq != FCC_SEQ_IDLE) || i_arr_addr[0])
        acc_set = 1'b1;
      else if (!locked)
      begin
        // may overwrite a queued command that has not yet moved on
        r_next.buf_job.addr = i_arr_addr;
        r_next.buf_job.data = i_arr_wdata;
        r_next.seq = FCC_SEQ_ADDR;
      end
    end

    if (i_reg_wr)
    begin
      if ((r_reg.seq == FCC_SEQ_ADDR) && (i_reg_addr == `FCC_OFS_CMD))
      begin
        if (fcc_cmd_ok(i_reg_wdata))
        begin
          r_next.buf_job.cmd = i_reg_wdata;
          r_next.seq = FCC_SEQ_CMD;
        end
        else
          acc_set = 1'b1;
      end
      else if ((r_reg.seq == FCC_SEQ_CMD) && (i_reg_addr == `FCC_OFS_STATUS))
      begin
        if (!i_reg_wdata[`FCC_BIT_CBE])
          acc_set = 1'b1;
        else if (pv_hit)
          pv_set = 1'b1;
        else if (!locked)
          go = 1'b1;
      end
      else if (r_reg.seq != FCC_SEQ_IDLE)
        acc_set = 1'b1;
      else
      begin
        case (i_reg_addr)
          `FCC_OFS_CLKDIV:
          begin
            r_next.div = i_reg_wdata[6:0];
            r_next.loaded = 1'b1;
          end
          `FCC_OFS_CONFIG:
          begin
            r_next.cbe_ie = i_reg_wdata[`FCC_BIT_CBE_IE];
            r_next.cc_ie = i_reg_wdata[`FCC_BIT_CC_IE];
          end
          `FCC_OFS_PROT:
          begin
            r_next.prot[2] = i_reg_wdata[`FCC_BIT_OPEN];
            r_next.prot[1] = i_reg_wdata[`FCC_BIT_HI_DIS];
            r_next.prot[0] = i_reg_wdata[`FCC_BIT_LO_DIS];
          end
          `FCC_OFS_STATUS:
          begin
            if (i_reg_wdata[`FCC_BIT_PROTECTION_VIOLATION_FLAG])
              r_next.protection_violation_flag = 1'b0;
            if (i_reg_wdata[`FCC_BIT_ACCESS_ERROR_FLAG])
              r_next.access_error_flag = 1'b0;
          end
          `FCC_OFS_CMD:
            acc_set = 1'b1;
          default:
          begin
          end
        endcase
      end
    end

    if (go)
    begin
      r_next.buf_valid = 1'b1;
      r_next.cbe = 1'b0;
      r_next.cc = 1'b0;
      r_next.blank = 1'b0;
      r_next.seq = FCC_SEQ_IDLE;
    end

    // error sets come after the write-one clears, so a set wins
    if (acc_set)
    begin
      r_next.access_error_flag = 1'b1;
      r_next.seq = FCC_SEQ_IDLE;
    end
    if (pv_set)
    begin
      r_next.protection_violation_flag = 1'b1;
      r_next.seq = FCC_SEQ_IDLE;
    end

    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `FCC_OFS_CLKDIV:
        begin
          rd[6:0] = r_reg.div;
          rd[`FCC_BIT_LOADED] = r_reg.loaded;
        end
        `FCC_OFS_CONFIG:
        begin
          rd[`FCC_BIT_CBE_IE] = r_reg.cbe_ie;
          rd[`FCC_BIT_CC_IE] = r_reg.cc_ie;
        end
        `FCC_OFS_PROT:
        begin
          rd[`FCC_BIT_OPEN] = r_reg.prot[2];
          rd[`FCC_BIT_HI_DIS] = r_reg.prot[1];
          rd[`FCC_BIT_LO_DIS] = r_reg.prot[0];
        end
        `FCC_OFS_STATUS:
        begin
          rd[`FCC_BIT_CBE] = r_reg.cbe;
          rd[`FCC_BIT_CC] = r_reg.cc;
          rd[`FCC_BIT_PROTECTION_VIOLATION_FLAG] = r_reg.protection_violation_flag;
          rd[`FCC_BIT_ACCESS_ERROR_FLAG] = r_reg.access_error_flag;
          rd[`FCC_BIT_BLANK] = r_reg.blank;
        end
        `FCC_OFS_CMD:
          rd = r_reg.buf_job.cmd;
        default:
          rd = 8'h00;
      endcase
      r_next.rdata = rd;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      r_reg <= RST;
    else if (i_ce)
      r_reg <= r_next;
  end

  assign o_reg_rdata = r_reg.rdata;
  assign o_arr_start = r_reg.arr_start;
  assign o_arr_busy = r_reg.act_valid;
  assign o_arr_job = r_reg.act_job;
  assign o_alg_tick = alg_tick && i_ce;
  assign o_cbe_irq = r_reg.cbe && r_reg.cbe_ie;
  assign o_cc_irq = r_reg.cc && r_reg.cc_ie;

  // helpers read only by the checks below
  logic div_wr;
  logic verify_act;
  assign div_wr = i_reg_wr && i_ce && (i_reg_addr == `FCC_OFS_CLKDIV) &&
    (r_reg.seq == FCC_SEQ_IDLE);
  assign verify_act = r_reg.act_valid && (r_reg.act_job.cmd == `FCC_CMD_VERIFY);

  default clocking fcc_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_launch_ack;
    go && i_ce |=> !r_reg.cc && !r_reg.cbe && r_reg.buf_valid;
  endproperty
  a_launch_ack: assert property (p_launch_ack)
    else $error("launch did not clear complete and buffer-empty");

  property p_refill;
    r_reg.buf_valid && !r_reg.act_valid && i_ce |=>
      r_reg.cbe && r_reg.act_valid && o_arr_start;
  endproperty
  a_refill: assert property (p_refill)
    else $error("buffered command not moved to active stage");

  property p_div_load;
    $rose(r_reg.loaded) |-> $past(div_wr);
  endproperty
  a_div_load: assert property (p_div_load)
    else $error("divider loaded flag set without a divider write");

  property p_no_div;
    i_arr_wr && i_ce && !r_reg.loaded |=> r_reg.access_error_flag && !r_reg.buf_valid ##1 !r_reg.buf_valid && !o_arr_start;
  endproperty
  a_no_div: assert property (p_no_div)
    else $error("array write before divider load not refused");

  property p_bad_cmd;
    i_reg_wr && i_ce && (r_reg.seq == FCC_SEQ_ADDR) &&
      (i_reg_addr == `FCC_OFS_CMD) && !fcc_cmd_ok(i_reg_wdata) |=>
      r_reg.access_error_flag && (r_reg.seq == FCC_SEQ_IDLE);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("invalid command code did not set access error");

  property p_locked;
    (r_reg.access_error_flag || r_reg.protection_violation_flag) && !r_reg.buf_valid && i_ce |=> !r_reg.buf_valid;
  endproperty
  a_locked: assert property (p_locked)
    else $error("command launched while an error flag is set");

  property p_cc_last;
    $rose(r_reg.cc) |-> !r_reg.act_valid && !r_reg.buf_valid && $past(done);
  endproperty
  a_cc_last: assert property (p_cc_last)
    else $error("complete set with work still pending");

  property p_blank;
    $rose(r_reg.blank) |-> $past(verify_act);
  endproperty
  a_blank: assert property (p_blank)
    else $error("blank set without an erase verify ending");

  property p_prot;
    i_reg_wr && i_ce && (r_reg.seq == FCC_SEQ_CMD) &&
      (i_reg_addr == `FCC_OFS_STATUS) && i_reg_wdata[`FCC_BIT_CBE] && pv_hit |=>
      r_reg.protection_violation_flag && !$rose(r_reg.buf_valid);
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected command launched or violation not flagged");

  c_launch: cover property (go && i_ce);
  c_chain: cover property (done && r_reg.buf_valid && i_ce);
  c_protection_violation_flag: cover property ($rose(r_reg.protection_violation_flag));
  c_blank: cover property ($rose(r_reg.blank));

endmodule // fcc_controller

`default_nettype wire

// ==== verif/fcc_array_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcc_consts.svh"

// stands in for the flash array behind the controller
module fcc_array_model
  import fcc_pkg::*;
(
  input wire logic i_sys_clk, // system clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_busy, // operation active
  input wire fcc_job_t i_job, // active job
  input wire logic i_tick, // algorithm clock tick
  input wire logic i_dirty, // bench: array holds a non-erased word
  output logic o_not_erased // non-erased word seen
);
  logic [3:0] scan_reg;
  logic idle_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || !i_busy)
      scan_reg <= 4'h0;
    else if (i_tick)
      scan_reg <= scan_reg + 4'h1;
    idle_reg <= i_sys_rst ? 1'b0 : !idle_reg;
  end

  // outside a verify the level means nothing, so it toggles instead of holding
  always_comb
  begin
    if (i_busy && i_job.cmd == `FCC_CMD_VERIFY)
      o_not_erased = i_dirty && scan_reg >= 4'h2;
    else
      o_not_erased = idle_reg;
  end
endmodule // fcc_array_model
`default_nettype wire

// ==== verif/tb_fcc_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcc_consts.svh"

module tb_fcc_controller;
  import fcc_pkg::*;
  logic sys_clk, sys_rst, ce, reg_wr, reg_rd, arr_wr, not_erased, dirty;
  logic arr_start, arr_busy, alg_tick, cbe_irq, cc_irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, rdata;
  logic [15:0] arr_addr, arr_wdata;
  fcc_job_t arr_job, last_job;
  int n_errors, check_count, n_start, cycles, busy_cycles;

  fcc_controller #(.TICKS_VERIFY(16'h0008), .TICKS_PROGRAM(16'h000c),
    .TICKS_SECTOR(16'h0028), .TICKS_MASS(16'h0028)) fcc_controller_inst (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_ce(ce), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_arr_wr(arr_wr), .i_arr_addr(arr_addr), .i_arr_wdata(arr_wdata),
    .i_arr_not_erased(not_erased), .o_arr_start(arr_start), .o_arr_busy(arr_busy),
    .o_arr_job(arr_job), .o_alg_tick(alg_tick), .o_cbe_irq(cbe_irq), .o_cc_irq(cc_irq));

  fcc_array_model fcc_array_model_inst (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
    .i_busy(arr_busy), .i_job(arr_job), .i_tick(alg_tick), .i_dirty(dirty),
    .o_not_erased(not_erased));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // the whole run needs a few hundred cycles; 20000 means a hang
  always @(posedge sys_clk)
  begin
    cycles++;
    if (arr_busy === 1'b1)
      busy_cycles++;
    if (arr_start === 1'b1)
    begin
      n_start++;
      last_job = arr_job;
    end
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task chk(input logic [39:0] s, input logic [39:0] e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("FAIL %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({32'h0, rdata}, {32'h0, e});
  endtask

  task seq(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    @(posedge sys_clk);
    arr_addr <= a;
    arr_wdata <= d;
    arr_wr <= 1'b1;
    @(posedge sys_clk);
    arr_wr <= 1'b0;
    wr(`FCC_OFS_CMD, c);
    wr(`FCC_OFS_STATUS, 8'h80);
  endtask

  // the first gap after a divider change may be partial, so skip two ticks
  task gap(input int e);
    int n;
    n = 0;
    repeat (2)
    begin
      @(negedge sys_clk);
      while (alg_tick !== 1'b1)
        @(negedge sys_clk);
    end
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (alg_tick !== 1'b1 && n < 100);
    chk(40'(n), 40'(e));
  endtask

  // busy may stay up across a buffered hand-over, so wait for a quiet stretch
  task wait_done;
    int q;
    q = 0;
    do
    begin
      @(posedge sys_clk);
      q = (arr_busy === 1'b0) ? q + 1 : 0;
    end
    while (q < 4);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    arr_wr = 1'b0;
    dirty = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    arr_addr = 16'h0000;
    arr_wdata = 16'h0000;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`FCC_OFS_STATUS, 8'hc0);
    rd(`FCC_OFS_CLKDIV, 8'h00);
    rd(3'h5, 8'h00);
    seq(16'h2000, 16'h0000, `FCC_CMD_PROGRAM);
    rd(`FCC_OFS_STATUS, 8'hd0);
    wr(`FCC_OFS_STATUS, 8'h10);
    rd(`FCC_OFS_STATUS, 8'hc0);
    wr(`FCC_OFS_CLKDIV, 8'h02);
    rd(`FCC_OFS_CLKDIV, 8'h82);
    gap(3);
    wr(`FCC_OFS_CLKDIV, 8'h40);
    rd(`FCC_OFS_CLKDIV, 8'hc0);
    gap(8);
    wr(`FCC_OFS_CLKDIV, 8'h00);
    gap(1);
    wr(`FCC_OFS_CONFIG, 8'hc0);
    @(negedge sys_clk);
    chk({38'h0, cbe_irq, cc_irq}, 40'h3);
    wr(`FCC_OFS_PROT, 8'h24);
    rd(`FCC_OFS_PROT, 8'h24);
    seq(16'h2000, 16'h0000, `FCC_CMD_PROGRAM);
    rd(`FCC_OFS_STATUS, 8'he0);
    wr(`FCC_OFS_STATUS, 8'h20);
    seq(16'h4400, 16'h0000, `FCC_CMD_SECTOR);
    rd(`FCC_OFS_STATUS, 8'he0);
    wr(`FCC_OFS_STATUS, 8'h20);
    seq(16'h0000, 16'h0000, `FCC_CMD_MASS);
    rd(`FCC_OFS_STATUS, 8'he0);
    wr(`FCC_OFS_STATUS, 8'h20);
    wr(`FCC_OFS_PROT, 8'ha4);
    seq(16'h2000, 16'h0000, 8'h11);
    rd(`FCC_OFS_STATUS, 8'hd0);
    seq(16'h2000, 16'h1234, `FCC_CMD_PROGRAM);
    repeat (10) @(posedge sys_clk);
    chk(40'(n_start), 40'h0);
    wr(`FCC_OFS_STATUS, 8'h10);
    rd(`FCC_OFS_STATUS, 8'hc0);
    seq(16'h2002, 16'hbeef, `FCC_CMD_PROGRAM);
    rd(`FCC_OFS_STATUS, 8'h80);
    wait_done();
    chk(40'(busy_cycles), 40'h0c);
    chk(last_job, {`FCC_CMD_PROGRAM, 16'h2002, 16'hbeef});
    rd(`FCC_OFS_STATUS, 8'hc0);
    seq(16'h4400, 16'h0000, `FCC_CMD_SECTOR);
    seq(16'h2004, 16'h1111, `FCC_CMD_PROGRAM);
    rd(`FCC_OFS_STATUS, 8'h00);
    chk({39'h0, cc_irq}, 40'h0);
    seq(16'h2006, 16'h2222, `FCC_CMD_PROGRAM);
    wait_done();
    chk(40'(n_start), 40'h3);
    chk(last_job, {`FCC_CMD_PROGRAM, 16'h2006, 16'h2222});
    rd(`FCC_OFS_STATUS, 8'hc0);
    seq(16'h2000, 16'h5555, `FCC_CMD_VERIFY);
    wait_done();
    rd(`FCC_OFS_STATUS, 8'hc4);
    dirty <= 1'b1;
    seq(16'h2000, 16'h5555, `FCC_CMD_VERIFY);
    wait_done();
    rd(`FCC_OFS_STATUS, 8'hc0);
    seq(16'h3000, 16'h0000, `FCC_CMD_MASS);
    wait_done();
    chk({32'h0, last_job.cmd}, 40'h41);
    chk(40'(n_start), 40'h6);
    seq(16'h2008, 16'h0000, `FCC_CMD_PROGRAM);
    wr(`FCC_OFS_STATUS, 8'h10);
    seq(16'h2008, 16'h0000, 8'h00);
    @(posedge sys_clk);
    arr_wr <= 1'b1;
    @(posedge sys_clk);
    arr_wr <= 1'b0;
    wr(`FCC_OFS_CONFIG, 8'hc0);
    rd(`FCC_OFS_STATUS, 8'hd0);
    wr(`FCC_OFS_STATUS, 8'h10);
    @(posedge sys_clk);
    arr_wr <= 1'b1;
    @(posedge sys_clk);
    arr_wr <= 1'b0;
    wr(`FCC_OFS_CMD, `FCC_CMD_PROGRAM);
    wr(`FCC_OFS_STATUS, 8'h00);
    rd(`FCC_OFS_STATUS, 8'hd0);
    chk(40'(n_start), 40'h7);
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(`FCC_OFS_CONFIG, 8'h00);
    @(negedge sys_clk);
    chk({39'h0, alg_tick}, 40'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(`FCC_OFS_CONFIG, 8'hc0);
    stop_test();
  end
endmodule // tb_fcc_controller
`default_nettype wire
